/* rtl/sadc_pkg.sv */
// Package for the successive-approximation converter sequencer
package sadc_pkg;

  // Register addresses (byte addresses on the peripheral port)
  localparam logic [19:0] TEST_TARGET_ADDR = 20'hf0013;
  localparam logic [19:0] MODE0_ADDR = 20'hfff30;
  localparam logic [19:0] CHAN_ADDR = 20'hfff31;
  localparam logic [19:0] MODE2_ADDR = 20'hf0010;
  localparam logic [19:0] UPPER_ADDR = 20'hf0011;
  localparam logic [19:0] LOWER_ADDR = 20'hf0012;
  localparam logic [19:0] RES_WIDE_ADDR = 20'hfff1e;
  localparam logic [19:0] RES_NARROW_ADDR = 20'hfff1f;

  // Reset values
  localparam logic [7:0] TEST_TARGET_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] MODE0_RST = 8'h00;
  localparam logic [7:0] MODE2_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'hff;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [15:0] RES_WIDE_RST = 16'h0000;
  localparam logic [7:0] RES_NARROW_RST = 8'h00;

  // Field positions
  localparam int MODE0_START_BIT = 7;
  localparam int MODE0_ENABLE_BIT = 0;
  localparam int MODE0_ONESHOT_BIT = 1;
  localparam int MODE0_HWNOWAIT_BIT = 2;
  localparam int MODE2_POSREF_HI = 7;
  localparam int MODE2_POSREF_LO = 6;
  localparam int MODE2_NEGREF_BIT = 5;
  localparam int MODE2_RANGE_BIT = 3;

  // Test target codes
  localparam logic [1:0] TEST_SEL_CHAN = 2'h0;
  localparam logic [1:0] TEST_SEL_NEG = 2'h2;
  localparam logic [1:0] TEST_SEL_POS = 2'h3;

  // Timing: sampling window and conversion clock period in ns
  localparam int SAMPLE_NS = 1000;
  localparam int CLK_NS = 100;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES_BITS = 12;

  // Sequencer states
  typedef enum logic [1:0] {sadc_idle, sadc_sample, sadc_compare} sadc_state_t;

  // Analog front-end control bundle
  typedef struct packed {
    logic sample;           // Sample-and-hold tracking input
    logic hold;             // Sample-and-hold holding voltage
    logic [1:0] src;        // 0 channel, 2 negative ref, 3 positive ref
    logic [7:0] channel;    // Channel select copy
    logic neg_ref_select;   // Negative reference pick
    logic [1:0] pos_ref;    // Positive reference pick
    logic [11:0] tap;       // Resistor string tap code
  } sadc_analog_t;

endpackage

/* rtl/sadc_sequencer.sv */
// Sequencer and register file of the 12-bit successive-approximation converter
// Overview of operation
// - Test target selects channel, negative or positive reference
// - Reference picks come from mode register two
// - Sample, then hold until conversion ends
// - Start by setting bit 11, tap half
// - Keep MSB when input at least tap
// - Trial bit 10, keep when input at least tap
// - Repeat trial down to bit 0
// - Latch result and raise end interrupt together
// - Out-of-window result neither stored nor signalled
// - Sequential mode repeats until start bit cleared
// - One-shot mode clears start bit when done
// - Start bit stays set in sequential/no-wait one-shot
// - Channel write aborts and restarts conversion
// - Wide and narrow results reset to zero
// - Result is rounded ratio times 4096
// - Window compares upper eight result bits
// - Start ignored while converter disabled
// - Start rewrite aborts and restarts conversion
`timescale 1ns/1ns
`default_nettype none

module sadc_sequencer #(
  parameter int SAMPLE_CYCLES = sadc_pkg::SAMPLE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [19:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  input wire logic comp_above,
  output var sadc_pkg::sadc_analog_t analog_ff,
  output logic conv_end_irq_ff,
  output logic busy_ff
);

  // Programmable registers and the result registers
  logic [7:0] mode_reg_zero_ff;
  logic [7:0] mode_reg_two_ff;
  logic [7:0] channel_select_reg_ff;
  logic [1:0] test_target_reg_ff;
  logic [7:0] upper_limit_reg_ff;
  logic [7:0] lower_limit_reg_ff;
  logic [15:0] result_reg_wide_ff;
  logic [7:0] result_reg_narrow_ff;
  // Sequencer state
  sadc_pkg::sadc_state_t state_ff;
  logic [11:0] successive_approx_reg_ff;
  logic [3:0] bit_idx_ff;
  logic [15:0] cnt_ff;

  // Decoded writes, mode fields and conversion step signals
  logic wr_mode0;
  logic wr_chan;
  logic start_write;
  logic conv_start_bit;
  logic converter_enable_bit;
  logic oneshot;
  logic hw_nowait;
  logic [11:0] decided;
  logic last_bit;
  logic in_window;
  logic [11:0] nxt_sar; // Decided bits plus the next trial bit

  assign wr_mode0 = reg_wr && (reg_addr == sadc_pkg::MODE0_ADDR);
  assign wr_chan = reg_wr && (reg_addr == sadc_pkg::CHAN_ADDR);
  assign conv_start_bit = mode_reg_zero_ff[sadc_pkg::MODE0_START_BIT];
  assign converter_enable_bit = mode_reg_zero_ff[sadc_pkg::MODE0_ENABLE_BIT];
  assign oneshot = mode_reg_zero_ff[sadc_pkg::MODE0_ONESHOT_BIT];
  assign hw_nowait = mode_reg_zero_ff[sadc_pkg::MODE0_HWNOWAIT_BIT];
  // Start write only counts when the same write sets the enable bit
  assign start_write = wr_mode0 && reg_wdata[sadc_pkg::MODE0_START_BIT]
    && reg_wdata[sadc_pkg::MODE0_ENABLE_BIT];
  // Current trial bit resolved by the comparator
  assign decided = comp_above ? successive_approx_reg_ff
    : (successive_approx_reg_ff & ~(12'h001 << bit_idx_ff));
  // Same value feeds the approximation register and the tap drive
  assign nxt_sar = decided | (12'h001 << (bit_idx_ff - 4'h1));
  assign last_bit = (state_ff == sadc_pkg::sadc_compare) && (bit_idx_ff == 4'h0);

  // Window check on the top eight bits; range bit picks inside or outside
  function automatic logic window_ok(input logic [11:0] v, input logic [7:0] up,
                                     input logic [7:0] lo, input logic outside);
    logic in_range;
    in_range = (v[11:4] >= lo) && (v[11:4] <= up);
    window_ok = outside ? !in_range : in_range;
  endfunction

  assign in_window = window_ok(decided, upper_limit_reg_ff, lower_limit_reg_ff,
    mode_reg_two_ff[sadc_pkg::MODE2_RANGE_BIT]);

  // Mode register zero; hardware clear of start bit in one-shot mode
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      mode_reg_zero_ff <= sadc_pkg::MODE0_RST;
    else if (wr_mode0)
    begin
      mode_reg_zero_ff <= reg_wdata;
      // Start request dropped when converter is disabled
      if (!reg_wdata[sadc_pkg::MODE0_ENABLE_BIT])
        mode_reg_zero_ff[sadc_pkg::MODE0_START_BIT] <= 1'b0;
    end
    else if (last_bit && oneshot && !hw_nowait && !wr_chan)
      // A channel rewrite on the last step restarts, so the start bit stays
      mode_reg_zero_ff[sadc_pkg::MODE0_START_BIT] <= 1'b0;
  end

  // Remaining software registers
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      mode_reg_two_ff <= sadc_pkg::MODE2_RST;
      channel_select_reg_ff <= sadc_pkg::CHAN_RST;
      test_target_reg_ff <= sadc_pkg::TEST_TARGET_RST[1:0];
      upper_limit_reg_ff <= sadc_pkg::UPPER_RST;
      lower_limit_reg_ff <= sadc_pkg::LOWER_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        sadc_pkg::MODE2_ADDR: mode_reg_two_ff <= reg_wdata;
        sadc_pkg::CHAN_ADDR: channel_select_reg_ff <= reg_wdata;
        // Upper six bits are not stored
        sadc_pkg::TEST_TARGET_ADDR: test_target_reg_ff <= reg_wdata[1:0];
        sadc_pkg::UPPER_ADDR: upper_limit_reg_ff <= reg_wdata;
        sadc_pkg::LOWER_ADDR: lower_limit_reg_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Conversion sequencer with the analog drive: tap and hold switch are
  // loaded at the same edge as the approximation register, so the comparator
  // always judges the trial value that is decided at the next edge
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state_ff <= sadc_pkg::sadc_idle;
      successive_approx_reg_ff <= 12'h000;
      bit_idx_ff <= 4'h0;
      cnt_ff <= 16'h0000;
      analog_ff <= '0;
    end
    else
    begin
      // Source selection follows the registers every cycle
      analog_ff.src <= test_target_reg_ff;
      analog_ff.channel <= channel_select_reg_ff;
      analog_ff.neg_ref_select <= mode_reg_two_ff[sadc_pkg::MODE2_NEGREF_BIT];
      analog_ff.pos_ref <= {mode_reg_two_ff[sadc_pkg::MODE2_POSREF_HI],
                            mode_reg_two_ff[sadc_pkg::MODE2_POSREF_LO]};
      if (start_write || (wr_chan && state_ff != sadc_pkg::sadc_idle))
      begin
        // Abort discards partial data and restarts from sampling
        state_ff <= sadc_pkg::sadc_sample;
        successive_approx_reg_ff <= 12'h000;
        cnt_ff <= 16'h0000;
        analog_ff.sample <= 1'b1;
        analog_ff.hold <= 1'b0;
        analog_ff.tap <= 12'h000;
      end
      else if (!conv_start_bit || !converter_enable_bit)
      begin
        state_ff <= sadc_pkg::sadc_idle;
        analog_ff.sample <= 1'b0;
        analog_ff.hold <= 1'b0;
      end
      else
      begin
        case (state_ff)
          sadc_pkg::sadc_idle:
          begin
            state_ff <= sadc_pkg::sadc_sample;
            cnt_ff <= 16'h0000;
            analog_ff.sample <= 1'b1;
          end
          sadc_pkg::sadc_sample:
          begin
            if (cnt_ff == 16'(SAMPLE_CYCLES - 1))
            begin
              // Enter hold with MSB trial set, tap at half reference
              state_ff <= sadc_pkg::sadc_compare;
              successive_approx_reg_ff <= 12'h800;
              bit_idx_ff <= 4'(sadc_pkg::RES_BITS - 1);
              analog_ff.sample <= 1'b0;
              analog_ff.hold <= 1'b1;
              analog_ff.tap <= 12'h800;
            end
            else
              cnt_ff <= cnt_ff + 16'h0001;
          end
          sadc_pkg::sadc_compare:
          begin
            // One bit per clock; the next lower bit is trial-set
            if (bit_idx_ff == 4'h0)
            begin
              // Sequential mode goes straight into the next sample
              state_ff <= (oneshot && !hw_nowait) ? sadc_pkg::sadc_idle
                : sadc_pkg::sadc_sample;
              cnt_ff <= 16'h0000;
              analog_ff.sample <= !(oneshot && !hw_nowait);
              analog_ff.hold <= 1'b0;
            end
            else
            begin
              successive_approx_reg_ff <= nxt_sar;
              bit_idx_ff <= bit_idx_ff - 4'h1;
              analog_ff.tap <= nxt_sar;
            end
          end
          default:
          begin
            state_ff <= sadc_pkg::sadc_idle;
            analog_ff.sample <= 1'b0;
            analog_ff.hold <= 1'b0;
          end
        endcase
      end
    end
  end

  // Result latch and end-of-conversion pulse, gated by the window
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      result_reg_wide_ff <= sadc_pkg::RES_WIDE_RST;
      result_reg_narrow_ff <= sadc_pkg::RES_NARROW_RST;
      conv_end_irq_ff <= 1'b0;
    end
    else
    begin
      conv_end_irq_ff <= 1'b0;
      // Comparator threshold at half-LSB offsets gives rounded ratio
      if (last_bit && !start_write && !wr_chan && in_window)
      begin
        result_reg_wide_ff <= {decided, 4'h0};
        result_reg_narrow_ff <= decided[11:4];
        conv_end_irq_ff <= 1'b1;
      end
    end
  end

  // Busy flag, one cycle behind the sequencer state
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      busy_ff <= 1'b0;
    else
      busy_ff <= (state_ff != sadc_pkg::sadc_idle);
  end

  // Register read port
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      reg_rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        sadc_pkg::MODE0_ADDR: reg_rdata_ff <= mode_reg_zero_ff;
        sadc_pkg::MODE2_ADDR: reg_rdata_ff <= mode_reg_two_ff;
        sadc_pkg::CHAN_ADDR: reg_rdata_ff <= channel_select_reg_ff;
        sadc_pkg::TEST_TARGET_ADDR: reg_rdata_ff <= {6'h00, test_target_reg_ff};
        sadc_pkg::UPPER_ADDR: reg_rdata_ff <= upper_limit_reg_ff;
        sadc_pkg::LOWER_ADDR: reg_rdata_ff <= lower_limit_reg_ff;
        sadc_pkg::RES_WIDE_ADDR: reg_rdata_ff <= result_reg_wide_ff[15:8];
        sadc_pkg::RES_NARROW_ADDR: reg_rdata_ff <= result_reg_narrow_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* tb/sadc_analog_model.sv */
// Analog stand-in: sample-and-hold, resistor ladder and comparator
`timescale 1ns/1ns
`default_nettype none
module sadc_analog_model (
  input wire logic sys_clk,
  input wire sadc_pkg::sadc_analog_t analog_ff,
  input wire logic [11:0] vin_code,
  output logic comp_above
);
  logic [11:0] held_ff; // Voltage frozen while the sample switch is off
  logic junk_ff = 1'b0; // Toggles so a stray comparator read is never lucky
  // Track the chosen source while sampling, freeze it otherwise
  always @(posedge sys_clk)
  begin
    junk_ff <= ~junk_ff;
    if (analog_ff.sample)
    begin
      // References give the ends of the ladder, channel gives the input
      held_ff <= (analog_ff.src == 2'h3) ? 12'hfff :
                 (analog_ff.src == 2'h2) ? 12'h000 : vin_code;
    end
  end
  // Ladder offset is ideal, so the comparator reads the code directly
  assign comp_above = analog_ff.hold ? (held_ff >= analog_ff.tap) : junk_ff;
endmodule
`default_nettype wire

/* tb/sadc_sequencer_chk.sv */
// Port checks for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sadc_sequencer_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [19:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic comp_above,
  input wire sadc_pkg::sadc_analog_t analog_ff,
  input wire logic conv_end_irq_ff,
  input wire logic busy_ff
);
  // Single domain, checks paused during reset
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  a_irq_one_pulse: assert property (conv_end_irq_ff |=> !conv_end_irq_ff)
    else $error("end pulse longer than one cycle");
  a_sh_exclusive: assert property (!(analog_ff.sample && analog_ff.hold))
    else $error("sample and hold both active");
  a_first_tap: assert property ($rose(analog_ff.hold) |-> analog_ff.tap == 12'h800)
    else $error("first tap not half scale");
  a_second_tap: assert property ($rose(analog_ff.hold) ##1 analog_ff.hold |->
    analog_ff.tap == {$past(comp_above), 11'h400})
    else $error("second tap wrong");
  a_tt_unused_zero: assert property (reg_rd && reg_addr == sadc_pkg::TEST_TARGET_ADDR
    |=> reg_rdata_ff[7:2] == 6'h00)
    else $error("test target upper bits not zero");
  a_src_legal: assert property (analog_ff.src != 2'h1)
    else $error("prohibited source code");
  a_start_ignored: assert property (reg_wr && reg_addr == sadc_pkg::MODE0_ADDR &&
    reg_wdata[7] && !reg_wdata[0] && !busy_ff |=> ##1 !busy_ff)
    else $error("start taken while disabled");
  a_irq_min_gap: assert property ($rose(busy_ff) |-> !conv_end_irq_ff [*8])
    else $error("conversion ended too early");
  c_irq: cover property (conv_end_irq_ff);
  c_abort: cover property (busy_ff && reg_wr && reg_addr == sadc_pkg::CHAN_ADDR);
  c_pos_ref: cover property (analog_ff.hold && analog_ff.src == 2'h3);
endmodule
bind sadc_sequencer sadc_sequencer_chk chk (.sys_clk(sys_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .comp_above(comp_above), .analog_ff(analog_ff),
  .conv_end_irq_ff(conv_end_irq_ff), .busy_ff(busy_ff));
`default_nettype wire

/* tb/sadc_sequencer_tb.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sadc_sequencer_tb;
  logic sys_clk, resetn, reg_wr, reg_rd, comp_above, conv_end_irq_ff, busy_ff, hit;
  logic [19:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_ff, q;
  logic [11:0] vin_code; // Input voltage as an ideal code
  sadc_pkg::sadc_analog_t analog_ff;
  int mismatches, checks;
  // Short sampling window keeps the run brief
  sadc_sequencer #(.SAMPLE_CYCLES(2)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .comp_above(comp_above), .analog_ff(analog_ff),
    .conv_end_irq_ff(conv_end_irq_ff), .busy_ff(busy_ff));
  sadc_analog_model fe (.sys_clk(sys_clk), .analog_ff(analog_ff), .vin_code(vin_code),
    .comp_above(comp_above));
  // 100 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Byte comparison
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Tasks start and end 10 ns after a rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    idle(1);
    reg_wr = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    idle(1);
    reg_rd = 1'b0;
    d = reg_rdata_ff;
    idle(1);
  endtask
  // Bounded wait for the one-cycle end pulse
  task automatic wait_irq(output logic h);
    int n;
    h = 1'b0;
    n = 0;
    while (!h && n < 40)
    begin
      idle(1);
      h = (conv_end_irq_ff === 1'b1);
      n++;
    end
  endtask
  // One conversion: target, mode, input, then pulse, result and mode readback
  task automatic conv(input logic [7:0] tt, md, input logic [11:0] v,
    input logic [7:0] irq, nb, mr);
    logic h;
    vin_code = v;
    wr(sadc_pkg::TEST_TARGET_ADDR, tt);
    wr(sadc_pkg::MODE0_ADDR, md);
    wait_irq(h);
    cmp({7'h0, h}, irq);
    rd(sadc_pkg::RES_NARROW_ADDR, q);
    cmp(q, nb);
    rd(sadc_pkg::MODE0_ADDR, q);
    cmp(q, mr);
    wr(sadc_pkg::MODE0_ADDR, 8'h01);
    idle(20);
  endtask
  // Hang guard, well past the expected run
  initial
  begin
    #400000;
    mismatches++;
    end_sim;
  end
  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 20'h00000;
    reg_wdata = 8'h00;
    vin_code = 12'h000;
    idle(3);
    resetn = 1'b1;
    rd(sadc_pkg::RES_WIDE_ADDR, q);
    cmp(q, 8'h00);
    rd(sadc_pkg::TEST_TARGET_ADDR, q);
    cmp(q, 8'h00);
    wr(sadc_pkg::TEST_TARGET_ADDR, 8'hff);
    rd(sadc_pkg::TEST_TARGET_ADDR, q);
    cmp(q, 8'h03);
    rd(20'h00000, q);
    cmp(q, 8'h00);
    // Start with the converter disabled must do nothing
    wr(sadc_pkg::MODE0_ADDR, 8'h80);
    idle(3);
    cmp({7'h0, busy_ff}, 8'h00);
    rd(sadc_pkg::MODE0_ADDR, q);
    cmp(q, 8'h00);
    wr(sadc_pkg::MODE0_ADDR, 8'h01);
    conv(8'h00, 8'h83, 12'ha5c, 8'h01, 8'ha5, 8'h03);
    conv(8'h00, 8'h87, 12'h3c1, 8'h01, 8'h3c, 8'h87);
    conv(8'h02, 8'h83, 12'ha5c, 8'h01, 8'h00, 8'h03);
    conv(8'h03, 8'h83, 12'ha5c, 8'h01, 8'hff, 8'h03);
    // Window edge: top eight bits equal to the limit pass, one above fails
    wr(sadc_pkg::UPPER_ADDR, 8'h5a);
    conv(8'h00, 8'h83, 12'h5af, 8'h01, 8'h5a, 8'h03);
    conv(8'h00, 8'h83, 12'h5b0, 8'h00, 8'h5a, 8'h03);
    // Range check bit set: only results outside the window are kept
    wr(sadc_pkg::MODE2_ADDR, 8'h08);
    conv(8'h00, 8'h83, 12'h5b0, 8'h01, 8'h5b, 8'h03);
    wr(sadc_pkg::MODE2_ADDR, 8'h00);
    wr(sadc_pkg::UPPER_ADDR, 8'hff);
    // Sequential runs on; channel rewrite restarts on the new input
    vin_code = 12'h3c0;
    wr(sadc_pkg::MODE0_ADDR, 8'h81);
    wait_irq(hit);
    wait_irq(hit);
    cmp({7'h0, hit}, 8'h01);
    rd(sadc_pkg::MODE0_ADDR, q);
    cmp(q, 8'h81);
    idle(5);
    vin_code = 12'h7e0;
    wr(sadc_pkg::CHAN_ADDR, 8'h01);
    wait_irq(hit);
    cmp({7'h0, hit}, 8'h01);
    rd(sadc_pkg::RES_NARROW_ADDR, q);
    cmp(q, 8'h7e);
    rd(sadc_pkg::RES_WIDE_ADDR, q);
    cmp(q, 8'h7e);
    wr(sadc_pkg::MODE0_ADDR, 8'h01);
    wait_irq(hit);
    cmp({7'h0, hit}, 8'h00);
    // Start rewrite in mid-conversion discards the partial result
    vin_code = 12'h111;
    wr(sadc_pkg::MODE0_ADDR, 8'h83);
    idle(5);
    vin_code = 12'h222;
    wr(sadc_pkg::MODE0_ADDR, 8'h83);
    wait_irq(hit);
    cmp({7'h0, hit}, 8'h01);
    rd(sadc_pkg::RES_NARROW_ADDR, q);
    cmp(q, 8'h22);
    end_sim;
  end
endmodule
`default_nettype wire
